// ===== core/ftc_timer.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ftc_timer (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output var  logic [7:0] rd_data,
    // cpu state
    input  wire logic       cpu_irq_mask,
    input  wire logic       halt_mode,
    // pins
    input  wire logic       capture_pin_one,
    input  wire logic       capture_pin_two,
    input  wire logic       external_timer_clock_pin,
    // interrupt request
    output var  logic       timer_irq
);

    ftc_pkg::ftc_state_t st;
    ftc_pkg::ftc_state_t next_st;
    ftc_pkg::ftc_bus_t   bus;

    logic [1:0] clk_sel;
    logic       tick;
    logic       reload;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [1:0] cap_evt;
    logic       ovf_evt;
    logic       cnt_lo_acc;
    logic       alt_lo_acc;
    logic [1:0] cap_lo_acc;

    // prescaler decode, called only by the tick logic
    function automatic logic presc_tick(input logic [1:0] sel, input logic [2:0] d);
        logic t;
        t = 1'b0;
        unique case (sel)
            ftc_pkg::CLK_DIV2: t = d[0];
            ftc_pkg::CLK_DIV4: t = &d[1:0];
            ftc_pkg::CLK_DIV8: t = &d;
            ftc_pkg::CLK_EXT:  t = 1'b0;
        endcase
        return t;
    endfunction

    // strobe bundle
    assign bus = '{addr: addr, wdata: wr_data, wr: wr_en, rd: rd_en};

    // pin edges from the second sync stage only
    assign rise = st.sync2 & ~st.pin_prev;
    assign fall = ~st.sync2 & st.pin_prev;

    assign clk_sel = {st.ctrl2[ftc_pkg::CTRL2_CLK_SEL_HI], st.ctrl2[ftc_pkg::CTRL2_CLK_SEL_LO]};

    // timer tick; external edge already resampled on core_clk
    always_comb begin
        if (clk_sel == ftc_pkg::CLK_EXT) begin
            tick = st.ctrl2[ftc_pkg::CTRL2_EXT_EDGE] ? rise[2] : fall[2];
        end else begin
            tick = presc_tick(clk_sel, st.div);
        end
    end

    // low byte accesses, read or write
    assign cnt_lo_acc    = (bus.rd || bus.wr) && bus.addr == ftc_pkg::OFS_COUNT_LOW;
    assign alt_lo_acc    = (bus.rd || bus.wr) && bus.addr == ftc_pkg::OFS_ALT_LOW;
    assign cap_lo_acc[0] = (bus.rd || bus.wr) && bus.addr == ftc_pkg::OFS_CAP1_LOW;
    assign cap_lo_acc[1] = (bus.rd || bus.wr) && bus.addr == ftc_pkg::OFS_CAP2_LOW;
    assign reload        = bus.wr && (bus.addr == ftc_pkg::OFS_COUNT_LOW
                                   || bus.addr == ftc_pkg::OFS_ALT_LOW);

    // halt freezes the count; wait has no effect here
    assign ovf_evt = tick && !halt_mode && !reload && st.count == ftc_pkg::COUNT_TOP;

    // capture events; channel one idle in one pulse or pwm mode
    assign cap_evt[0] = (st.ctrl1[ftc_pkg::CTRL1_CAP1_EDGE] ? rise[0] : fall[0])
                        && !st.ctrl2[ftc_pkg::CTRL2_OPM_MODE]
                        && !st.ctrl2[ftc_pkg::CTRL2_PWM_MODE]
                        && !st.cap_lock[0];
    assign cap_evt[1] = (st.ctrl2[ftc_pkg::CTRL2_CAP2_EDGE] ? rise[1] : fall[1])
                        && !st.cap_lock[1];

    // next state
    always_comb begin
        next_st = st;
        next_st.sync1    = {external_timer_clock_pin, capture_pin_two, capture_pin_one};
        next_st.sync2    = st.sync1;
        next_st.pin_prev = st.sync2;
        next_st.div      = st.div + 3'h1;
        next_st.rd_data  = 8'h00;

        // counter
        if (reload) begin
            next_st.count = ftc_pkg::COUNT_RESET;
        end else if (tick && !halt_mode) begin
            next_st.count = st.count + 16'h0001;
        end

        // control writes
        if (bus.wr && bus.addr == ftc_pkg::OFS_CTRL_ONE) begin
            next_st.ctrl1 = bus.wdata;
        end
        if (bus.wr && bus.addr == ftc_pkg::OFS_CTRL_TWO) begin
            next_st.ctrl2 = bus.wdata;
        end

        // status read arms the clear of each flag that is set
        if (bus.rd && bus.addr == ftc_pkg::OFS_STATUS) begin
            next_st.ovf_arm = st.ovf_arm | st.ovf_flag;
            next_st.cap_arm = st.cap_arm | st.cap_flag;
        end

        // overflow flag: set wins over clear; alternate low is ignored
        if (cnt_lo_acc && st.ovf_arm) begin
            next_st.ovf_flag = 1'b0;
            next_st.ovf_arm  = 1'b0;
        end
        if (ovf_evt) begin
            next_st.ovf_flag = 1'b1;
        end

        // capture channels
        for (int i = 0; i < 2; i++) begin
            if (cap_lo_acc[i] && st.cap_arm[i]) begin
                next_st.cap_flag[i] = 1'b0;
                next_st.cap_arm[i]  = 1'b0;
            end
            if (cap_evt[i]) begin
                next_st.cap_val[i]  = st.count;
                next_st.cap_flag[i] = 1'b1;
            end
        end

        // capture high read locks, low read unlocks
        if (bus.rd && bus.addr == ftc_pkg::OFS_CAP1_HIGH) begin
            next_st.cap_lock[0] = 1'b1;
        end
        if (bus.rd && bus.addr == ftc_pkg::OFS_CAP2_HIGH) begin
            next_st.cap_lock[1] = 1'b1;
        end
        if (bus.rd && bus.addr == ftc_pkg::OFS_CAP1_LOW) begin
            next_st.cap_lock[0] = 1'b0;
        end
        if (bus.rd && bus.addr == ftc_pkg::OFS_CAP2_LOW) begin
            next_st.cap_lock[1] = 1'b0;
        end

        // read data, answered one cycle later
        if (bus.rd) begin
            unique case (bus.addr)
                ftc_pkg::OFS_CTRL_ONE:  next_st.rd_data = st.ctrl1;
                ftc_pkg::OFS_CTRL_TWO:  next_st.rd_data = st.ctrl2;
                ftc_pkg::OFS_STATUS: begin
                    next_st.rd_data[ftc_pkg::STAT_CAP1_FLAG] = st.cap_flag[0];
                    next_st.rd_data[ftc_pkg::STAT_CAP2_FLAG] = st.cap_flag[1];
                    next_st.rd_data[ftc_pkg::STAT_OVF_FLAG]  = st.ovf_flag;
                end
                ftc_pkg::OFS_COUNT_HIGH: begin
                    next_st.rd_data = st.count[15:8];
                    if (!st.cnt_held) begin
                        next_st.cnt_held = 1'b1;
                        next_st.cnt_buf  = st.count[7:0];
                    end
                end
                ftc_pkg::OFS_COUNT_LOW: begin
                    next_st.rd_data  = st.cnt_held ? st.cnt_buf : st.count[7:0];
                    next_st.cnt_held = 1'b0;
                end
                ftc_pkg::OFS_ALT_HIGH: begin
                    next_st.rd_data = st.count[15:8];
                    if (!st.alt_held) begin
                        next_st.alt_held = 1'b1;
                        next_st.alt_buf  = st.count[7:0];
                    end
                end
                ftc_pkg::OFS_ALT_LOW: begin
                    next_st.rd_data  = st.alt_held ? st.alt_buf : st.count[7:0];
                    next_st.alt_held = 1'b0;
                end
                ftc_pkg::OFS_CAP1_HIGH: next_st.rd_data = st.cap_val[0][15:8];
                ftc_pkg::OFS_CAP1_LOW:  next_st.rd_data = st.cap_val[0][7:0];
                ftc_pkg::OFS_CAP2_HIGH: next_st.rd_data = st.cap_val[1][15:8];
                ftc_pkg::OFS_CAP2_LOW:  next_st.rd_data = st.cap_val[1][7:0];
                default:                next_st.rd_data = 8'h00;
            endcase
        end

        // request stays pending in the flags until mask clears
        next_st.irq = !cpu_irq_mask
                      && ((next_st.ovf_flag && next_st.ctrl1[ftc_pkg::CTRL1_OVF_IRQ_EN])
                      || ((|next_st.cap_flag) && next_st.ctrl1[ftc_pkg::CTRL1_CAP_IRQ_EN]));
    end

    // state register; pin samplers idle high so reset makes no false edge
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st          <= '0;
            st.count    <= ftc_pkg::COUNT_RESET;
            st.ctrl1    <= ftc_pkg::CTRL_RESET;
            st.ctrl2    <= ftc_pkg::CTRL_RESET;
            st.sync1    <= ftc_pkg::PIN_IDLE;
            st.sync2    <= ftc_pkg::PIN_IDLE;
            st.pin_prev <= ftc_pkg::PIN_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data   = st.rd_data;
    assign timer_irq = st.irq;

    // checks
    AST_RELOAD: assert property (@(posedge core_clk) disable iff (!rstn)
        reload |=> st.count == ftc_pkg::COUNT_RESET)
        else $error("low byte write did not reload the counter");

    AST_OVF_SET: assert property (@(posedge core_clk) disable iff (!rstn)
        ovf_evt |=> st.ovf_flag && st.count == 16'h0000)
        else $error("rollover did not set the overflow flag");

    AST_ALT_KEEPS: assert property (@(posedge core_clk) disable iff (!rstn)
        (alt_lo_acc && st.ovf_flag) |=> st.ovf_flag)
        else $error("alternate low access cleared the overflow flag");

    AST_HALT_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        (halt_mode && !reload) |=> $stable(st.count))
        else $error("counter moved in halt");

    AST_BUF_FROZEN: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus.rd && bus.addr == ftc_pkg::OFS_COUNT_LOW && st.cnt_held)
        |=> rd_data == $past(st.cnt_buf))
        else $error("low read did not return the buffered byte");

    AST_LIVE_LOW: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus.rd && bus.addr == ftc_pkg::OFS_COUNT_LOW && !st.cnt_held)
        |=> rd_data == $past(st.count[7:0]))
        else $error("lone low read did not return the live count");

    AST_CAP_LOCK: assert property (@(posedge core_clk) disable iff (!rstn)
        st.cap_lock[1] |=> $stable(st.cap_val[1]) && !($rose(st.cap_flag[1])))
        else $error("capture landed while locked");

    AST_CH1_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.ctrl2[ftc_pkg::CTRL2_OPM_MODE] || st.ctrl2[ftc_pkg::CTRL2_PWM_MODE])
        |=> $stable(st.cap_val[0]))
        else $error("channel one captured in one pulse or pwm mode");

    AST_CAPTURE: assert property (@(posedge core_clk) disable iff (!rstn)
        cap_evt[1] |=> st.cap_val[1] == $past(st.count) && st.cap_flag[1])
        else $error("capture did not latch the count");

    AST_IRQ_MASK: assert property (@(posedge core_clk) disable iff (!rstn)
        cpu_irq_mask |=> !timer_irq)
        else $error("interrupt raised while masked");

    AST_DIV2: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_sel == ftc_pkg::CLK_DIV2 && tick) |=> !tick)
        else $error("divide by two ticked twice in a row");

    AST_RESET_STATE: assert property (@(posedge core_clk)
        !rstn |=> st.count == ftc_pkg::COUNT_RESET && !timer_irq && rd_data == 8'h00)
        else $error("reset did not restore the counter and outputs");

    AST_OVF_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn)
        (cnt_lo_acc && st.ovf_arm && !ovf_evt) |=> !st.ovf_flag)
        else $error("armed low access did not clear the overflow flag");

    AST_OVF_NEEDS_ARM: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.ovf_flag && !st.ovf_arm) |=> st.ovf_flag)
        else $error("overflow flag cleared without a status read");

    AST_CAP_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn)
        (cap_lo_acc[0] && st.cap_arm[0] && !cap_evt[0]) |=> !st.cap_flag[0])
        else $error("armed low capture access did not clear the flag");

    AST_CAP1_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
        cap_evt[0] |=> st.cap_val[0] == $past(st.count) && st.cap_flag[0])
        else $error("channel one capture did not latch the count");

    AST_CAP1_LOCK: assert property (@(posedge core_clk) disable iff (!rstn)
        st.cap_lock[0] |=> $stable(st.cap_val[0]) && !($rose(st.cap_flag[0])))
        else $error("channel one capture landed while locked");

    AST_EXT_COUNT: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_sel == ftc_pkg::CLK_EXT && !halt_mode && !reload
         && st.sync2[2] != st.pin_prev[2]
         && st.sync2[2] == st.ctrl2[ftc_pkg::CTRL2_EXT_EDGE])
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("external edge did not advance the counter");

    AST_EXT_IGNORE: assert property (@(posedge core_clk) disable iff (!rstn)
        (clk_sel == ftc_pkg::CLK_EXT && !reload
         && (st.sync2[2] == st.pin_prev[2]
          || st.sync2[2] != st.ctrl2[ftc_pkg::CTRL2_EXT_EDGE]))
        |=> $stable(st.count))
        else $error("external clock advanced on an unselected transition");

    AST_LOW_BUF_KEEP: assert property (@(posedge core_clk) disable iff (!rstn)
        (st.cnt_held && !(bus.rd && bus.addr == ftc_pkg::OFS_COUNT_LOW))
        |=> st.cnt_held && $stable(st.cnt_buf))
        else $error("buffered low byte changed before the low read");

    AST_ALT_BUF: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus.rd && bus.addr == ftc_pkg::OFS_ALT_HIGH && !st.alt_held)
        |=> st.alt_held && st.alt_buf == $past(st.count[7:0]))
        else $error("alternate high read did not buffer the low byte");

    AST_IRQ_PENDING: assert property (@(posedge core_clk) disable iff (!rstn)
        (!cpu_irq_mask && !(bus.wr && bus.addr == ftc_pkg::OFS_CTRL_ONE)
         && ((st.ovf_flag && !cnt_lo_acc && st.ctrl1[ftc_pkg::CTRL1_OVF_IRQ_EN])
          || (st.cap_flag[0] && !cap_lo_acc[0] && st.ctrl1[ftc_pkg::CTRL1_CAP_IRQ_EN])))
        |=> timer_irq)
        else $error("pending request not raised once unmasked");

endmodule

`default_nettype wire

// ===== core/ftc_pkg.sv
package ftc_pkg;

    // register byte offsets
    localparam logic [3:0] OFS_CTRL_TWO   = 4'h0;
    localparam logic [3:0] OFS_CTRL_ONE   = 4'h1;
    localparam logic [3:0] OFS_STATUS     = 4'h2;
    localparam logic [3:0] OFS_CAP1_HIGH  = 4'h4;
    localparam logic [3:0] OFS_CAP1_LOW   = 4'h5;
    localparam logic [3:0] OFS_COUNT_HIGH = 4'h8;
    localparam logic [3:0] OFS_COUNT_LOW  = 4'h9;
    localparam logic [3:0] OFS_ALT_HIGH   = 4'ha;
    localparam logic [3:0] OFS_ALT_LOW    = 4'hb;
    localparam logic [3:0] OFS_CAP2_HIGH  = 4'hc;
    localparam logic [3:0] OFS_CAP2_LOW   = 4'hd;

    // first control register fields
    localparam int CTRL1_CAP_IRQ_EN = 7;
    localparam int CTRL1_OVF_IRQ_EN = 5;
    localparam int CTRL1_CAP1_EDGE  = 1;

    // second control register fields
    localparam int CTRL2_PWM_MODE   = 5;
    localparam int CTRL2_OPM_MODE   = 4;
    localparam int CTRL2_CLK_SEL_HI = 3;
    localparam int CTRL2_CLK_SEL_LO = 2;
    localparam int CTRL2_CAP2_EDGE  = 1;
    localparam int CTRL2_EXT_EDGE   = 0;

    // status register fields
    localparam int STAT_CAP1_FLAG = 7;
    localparam int STAT_CAP2_FLAG = 6;
    localparam int STAT_OVF_FLAG  = 5;

    // timer clock selections
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV4 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT  = 2'h3;

    // values after reset, and the last count before rollover
    localparam logic [15:0] COUNT_RESET = 16'hfffc;
    localparam logic [15:0] COUNT_TOP   = 16'hffff;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [2:0]  PIN_IDLE    = 3'h7;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ftc_bus_t;

    // all state of the timer
    typedef struct packed {
        logic [15:0]      count;
        logic [2:0]       div;
        logic [2:0]       sync1;
        logic [2:0]       sync2;
        logic [2:0]       pin_prev;
        logic [7:0]       ctrl1;
        logic [7:0]       ctrl2;
        logic             ovf_flag;
        logic [1:0]       cap_flag;
        logic             ovf_arm;
        logic [1:0]       cap_arm;
        logic             cnt_held;
        logic [7:0]       cnt_buf;
        logic             alt_held;
        logic [7:0]       alt_buf;
        logic [1:0]       cap_lock;
        logic [1:0][15:0] cap_val;
        logic [7:0]       rd_data;
        logic             irq;
    } ftc_state_t;

endpackage

// ===== verification/ftc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module ftc_pin_model (
    // clock
    input  wire logic core_clk,
    // pins toward the timer
    output var  logic cap_one,
    output var  logic cap_two,
    output var  logic ext_clk
);
    // pins idle high, matching the timer's synchroniser reset level
    initial begin
        cap_one = 1'b1;
        cap_two = 1'b1;
        ext_clk = 1'b1;
    end

    // toggle one pin, then hold it; eight clocks covers the synchroniser delay
    task automatic flip(input int pin);
        @(posedge core_clk);
        case (pin)
            0: cap_one <= ~cap_one;
            1: cap_two <= ~cap_two;
            default: ext_clk <= ~ext_clk;
        endcase
        repeat (8) @(posedge core_clk); // active edges far apart
        #1;
    endtask
endmodule

`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        core_clk;
    logic        rstn;
    logic [3:0]  addr;
    logic [7:0]  wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rd_data;
    logic        cpu_irq_mask;
    logic        halt_mode;
    logic        cap_one;
    logic        cap_two;
    logic        ext_clk;
    logic        timer_irq;
    logic [15:0] v;
    logic [15:0] w;
    logic [7:0]  r;
    logic [1:0]  lvl;
    logic        xl;
    logic        f;
    int          error_cnt;
    int          cmp_count;
    int          seed;
    int          k;

    ftc_timer i_ftc_timer (
        .core_clk                 (core_clk),
        .rstn                     (rstn),
        .addr                     (addr),
        .wr_data                  (wr_data),
        .wr_en                    (wr_en),
        .rd_en                    (rd_en),
        .rd_data                  (rd_data),
        .cpu_irq_mask             (cpu_irq_mask),
        .halt_mode                (halt_mode),
        .capture_pin_one          (cap_one),
        .capture_pin_two          (cap_two),
        .external_timer_clock_pin (ext_clk),
        .timer_irq                (timer_irq)
    );

    ftc_pin_model i_ftc_pin_model (
        .core_clk (core_clk),
        .cap_one  (cap_one),
        .cap_two  (cap_two),
        .ext_clk  (ext_clk)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        wr_en   <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    // high byte first so the low byte comes from the buffer
    task automatic rd16(input logic [3:0] a, output logic [15:0] d);
        logic [7:0] h;
        logic [7:0] l;
        rd(a, h);
        rd(a + 4'h1, l);
        d = {h, l};
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        rd(a, r);
        chk(r & m, exp);
    endtask

    task automatic chk_in(input logic [15:0] got, input int lo, input int hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    // let the counter run for n clocks, then freeze it again
    task automatic run(input int n);
        @(posedge core_clk);
        halt_mode <= 1'b0;
        repeat (n) @(posedge core_clk);
        halt_mode <= 1'b1;
    endtask

    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // how many of k toggles starting from level s arrive at level e
    function automatic int hits(input logic s, input int k, input logic e);
        return (e != s) ? (k + 1) / 2 : k / 2;
    endfunction

    task automatic conclude;
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // cut a hang short; the whole run needs under a thousand clocks
    initial begin
        #(50 * 20000);
        error_cnt++;
        conclude();
    end

    initial begin
        seed = 32'hccc8;
        error_cnt = 0;
        cmp_count = 0;
        addr = 4'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        cpu_irq_mask = 1'b1;
        halt_mode = 1'b1;
        lvl = 2'h3;
        xl = 1'b1;
        rstn = 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        // halted straight out of reset, so the reset count is visible
        rd16(ftc_pkg::OFS_COUNT_HIGH, v);
        chk(v, ftc_pkg::COUNT_RESET);
        rd16(ftc_pkg::OFS_ALT_HIGH, v);
        chk(v, ftc_pkg::COUNT_RESET);
        rd_chk(ftc_pkg::OFS_CTRL_ONE, 8'hff, ftc_pkg::CTRL_RESET);
        rd_chk(4'h3, 8'hff, 8'h00);
        // each prescaler: reload through either low byte, then count
        for (int d = 0; d < 3; d++) begin
            k = 64 >> (d + 1);
            wr(ftc_pkg::OFS_CTRL_TWO, 8'(d << 2));
            wr(d == 1 ? ftc_pkg::OFS_ALT_LOW : ftc_pkg::OFS_COUNT_LOW, 8'($random(seed)));
            rd16(ftc_pkg::OFS_COUNT_HIGH, v);
            chk(v, ftc_pkg::COUNT_RESET);
            run(64);
            rd16(ftc_pkg::OFS_COUNT_HIGH, v);
            chk_in(v - ftc_pkg::COUNT_RESET, k - 2, k + 1);
        end
        // repeated high reads keep the first buffered low byte
        rd(ftc_pkg::OFS_COUNT_HIGH, r);
        run(20);
        rd(ftc_pkg::OFS_COUNT_HIGH, r);
        rd_chk(ftc_pkg::OFS_COUNT_LOW, 8'hff, v[7:0]);
        repeat (40) @(posedge core_clk);
        rd16(ftc_pkg::OFS_ALT_HIGH, w);
        rd_chk(ftc_pkg::OFS_COUNT_LOW, 8'hff, w[7:0]);
        // overflow happened above; interrupt needs enable and open mask
        rd_chk(ftc_pkg::OFS_STATUS, 8'h20, 8'h20);
        wr(ftc_pkg::OFS_CTRL_ONE, 8'h20);
        settle();
        chk(timer_irq, 1'b0);
        @(posedge core_clk);
        cpu_irq_mask <= 1'b0;
        settle();
        chk(timer_irq, 1'b1);
        rd(ftc_pkg::OFS_ALT_LOW, r);
        rd_chk(ftc_pkg::OFS_STATUS, 8'h20, 8'h20);
        rd(ftc_pkg::OFS_COUNT_LOW, r);
        rd_chk(ftc_pkg::OFS_STATUS, 8'h20, 8'h00);
        settle();
        chk(timer_irq, 1'b0);
        wr(ftc_pkg::OFS_CTRL_ONE, 8'h80);
        // external clock counts only the selected transition
        @(posedge core_clk);
        halt_mode <= 1'b0;
        for (int e = 0; e < 2; e++) begin
            k = ($random(seed) & 7) + 1;
            wr(ftc_pkg::OFS_CTRL_TWO, 8'h0c | 8'(e));
            wr(ftc_pkg::OFS_COUNT_LOW, 8'($random(seed)));
            repeat (k) i_ftc_pin_model.flip(2);
            rd16(ftc_pkg::OFS_COUNT_HIGH, v);
            chk(v, ftc_pkg::COUNT_RESET + hits(xl, k, e[0]));
            xl = xl ^ k[0];
        end
        // both channels, both edge selections; the counter stands at v
        for (int t = 0; t < 4; t++) begin
            wr(ftc_pkg::OFS_CTRL_ONE, t[1] ? 8'h82 : 8'h80);
            wr(ftc_pkg::OFS_CTRL_TWO, t[1] ? 8'h0f : 8'h0d);
            i_ftc_pin_model.flip(t[0]);
            f = hits(lvl[t[0]], 1, t[1]) != 0;
            lvl[t[0]] = ~lvl[t[0]];
            chk(timer_irq, f);
            rd_chk(ftc_pkg::OFS_STATUS, 8'h80 >> t[0], f ? 8'h80 >> t[0] : 8'h00);
            rd16(t[0] ? ftc_pkg::OFS_CAP2_HIGH : ftc_pkg::OFS_CAP1_HIGH, w);
            if (f) begin
                chk(w, v);
            end
        end
        rd_chk(ftc_pkg::OFS_STATUS, 8'hc0, 8'h00);
        // a high capture read blocks the channel until the low read
        rd(ftc_pkg::OFS_CAP1_HIGH, r);
        repeat (2) i_ftc_pin_model.flip(0);
        rd_chk(ftc_pkg::OFS_STATUS, 8'h80, 8'h00);
        rd(ftc_pkg::OFS_CAP1_LOW, r);
        rd_chk(ftc_pkg::OFS_STATUS, 8'h80, 8'h00);
        // one pulse and pwm modes leave only channel two
        for (int m = 0; m < 2; m++) begin
            wr(ftc_pkg::OFS_CTRL_TWO, m ? 8'h2c : 8'h1c);
            repeat (2) i_ftc_pin_model.flip(0);
            repeat (2) i_ftc_pin_model.flip(1);
            rd_chk(ftc_pkg::OFS_STATUS, 8'hc0, 8'h40);
            rd(ftc_pkg::OFS_CAP2_LOW, r);
        end
        // reset wake-up restarts from the reset count, not the held one
        wr(ftc_pkg::OFS_CTRL_TWO, 8'h00);
        run(20);
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        rd16(ftc_pkg::OFS_COUNT_HIGH, v);
        chk(v, ftc_pkg::COUNT_RESET);
        conclude();
    end
endmodule

`default_nettype wire
